//--- core/lamp_switch_defs.vh
// constants for the dual lamp switch serial slave and control pins
// assumes a 25 MHz system clock; included by bare name
`ifndef LAMP_SWITCH_DEFS_VH
`define LAMP_SWITCH_DEFS_VH

// =====================================================================
// frame layout
`define FRAME_BITS      16
`define BIT_CNT_W       5
`define BIT_CNT_FULL    5'h10
`define BIT_CNT_MAX     5'h1f
`define ADDR_MSB        15
`define ADDR_LSB        11
`define DATA_MSB        10
`define NUM_REGS        32
`define DATA_W          11
`define DATA_RESET      11'h000

// =====================================================================
// control register addresses and field positions
`define ADDR_OUT_CTRL   5'h01
`define ADDR_PWM_CTRL   5'h02
`define ADDR_SENSE_CTRL 5'h03
`define OUT0_BIT        0
`define OUT1_BIT        1
`define PWM_EN_BIT      0
`define CLK_SEL_BIT     1
`define SENSE_SEL_LSB   0
`define SENSE_SEL_MSB   1
`define SENSE_HIZ       2'h0
`define SENSE_OUT0      2'h1
`define SENSE_OUT1      2'h2
`define SENSE_TEMP      2'h3

// =====================================================================
// pwm prescale and clock-failure watch
`define PWM_DIV         128
`define PWM_DIV_W       7
`define PWM_DIV_LAST    7'h7f
`define CLKFAIL_LIMIT   16'h3000
`define CLKFAIL_W       16

`endif

//--- core/edge_sync.v
// two-flop synchroniser with rise and fall pulses on the synced level
// assumes the input is asynchronous to clk; synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

// idle level of the pin is the reset value, so no false edge after reset
module edge_sync #(
    parameter IDLE = 1'b0
) (
    input  wire clk,
    input  wire rst,
    input  wire din,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    // =================================================================
    // synchronise; meta_q feeds only sync_q
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= IDLE;
            sync_q <= IDLE;
            prev_q <= IDLE;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;
endmodule // edge_sync

`default_nettype wire

//--- core/lamp_spi_slave.v
// serial slave, control pins, wake, fail-safe and sense select
// assumes REF_CLK at 25 MHz, serial clock at most about 3 MHz so that
// oversampling sees every edge; pins asynchronous to REF_CLK
`timescale 1ns/1ps
`default_nettype none
`include "lamp_switch_defs.vh"

module lamp_spi_slave (
    input  wire        REF_CLK,
    input  wire        SRST,
    input  wire        CHIP_SELECT_LOW,
    input  wire        SERIAL_CLK,
    input  wire        SERIAL_IN,
    output wire        SERIAL_OUT,
    output wire        SERIAL_OUT_OE,
    input  wire        DEVICE_RESET_LOW,
    input  wire        WAKE,
    input  wire        DIRECT_INPUT_ZERO,
    input  wire        DIRECT_INPUT_ONE,
    input  wire        LOGIC_SUPPLY_OK,
    input  wire        FAULT_DETECTED,
    input  wire [15:0] STATUS_WORD,
    output reg         SWITCH_OUTPUT_ZERO,
    output reg         SWITCH_OUTPUT_ONE,
    output wire        FAULT_FLAG_LOW_OUT,
    output wire        FAULT_FLAG_LOW_OE,
    output reg  [1:0]  SENSE_SELECT,
    output reg         SENSE_OUTPUT_HIZ,
    output reg         AWAKE,
    output reg         FAIL_SAFE,
    output reg         WATCHDOG_START,
    output reg         PWM_TICK,
    output reg         CLOCK_FAIL
);
    // =================================================================
    // pin synchronisers
    wire cs_lvl;
    wire cs_rise;
    wire cs_fall;
    wire sck_rise;
    wire sck_fall;
    wire si_lvl;
    wire rst_lvl;
    wire rst_rise;
    wire in0_lvl;
    wire in0_rise;
    wire in1_lvl;
    wire wake_lvl;
    wire vdd_ok;

    // select, device reset and supply good idle high
    edge_sync #(.IDLE(1'b1)) u_cs (.clk(REF_CLK), .rst(SRST),
        .din(CHIP_SELECT_LOW),
        .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
    edge_sync u_sck (.clk(REF_CLK), .rst(SRST), .din(SERIAL_CLK),
        .level(), .rise(sck_rise), .fall(sck_fall));
    edge_sync u_si (.clk(REF_CLK), .rst(SRST), .din(SERIAL_IN),
        .level(si_lvl), .rise(), .fall());
    edge_sync #(.IDLE(1'b1)) u_rst (.clk(REF_CLK), .rst(SRST),
        .din(DEVICE_RESET_LOW),
        .level(rst_lvl), .rise(rst_rise), .fall());
    edge_sync u_in0 (.clk(REF_CLK), .rst(SRST), .din(DIRECT_INPUT_ZERO),
        .level(in0_lvl), .rise(in0_rise), .fall());
    edge_sync u_in1 (.clk(REF_CLK), .rst(SRST), .din(DIRECT_INPUT_ONE),
        .level(in1_lvl), .rise(), .fall());
    edge_sync u_wake (.clk(REF_CLK), .rst(SRST), .din(WAKE),
        .level(wake_lvl), .rise(), .fall());
    edge_sync #(.IDLE(1'b1)) u_vdd (.clk(REF_CLK), .rst(SRST),
        .din(LOGIC_SUPPLY_OK),
        .level(vdd_ok), .rise(), .fall());

    // selected means select low after sync
    wire sel = ~cs_lvl;
    // device reset held low clears all but the AWAKE, FAIL_SAFE, WATCHDOG_START and pin synchroniser flops
    wire dev_rst = SRST | ~rst_lvl;

    // =================================================================
    // serial shifter state
    reg [15:0]             rx_q;
    reg [15:0]             tx_q;
    reg [`BIT_CNT_W-1:0]   cnt_q;
    reg [`DATA_W-1:0]      regs_q [0:`NUM_REGS-1];
    reg                    pwm_clk_on_q;
    integer                i;

    wire [4:0] frame_addr = rx_q[`ADDR_MSB:`ADDR_LSB];

    // sample on falling, shift out on rising
    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            rx_q  <= 16'h0000;
            tx_q  <= 16'h0000;
            cnt_q <= 5'h00;
        end else if (cs_fall) begin
            tx_q  <= STATUS_WORD;
            cnt_q <= 5'h00;
        end else if (sel) begin
            if (sck_fall) begin
                rx_q <= {rx_q[14:0], si_lvl};
                if (cnt_q != `BIT_CNT_MAX)
                    cnt_q <= cnt_q + 5'h01;
            end
            if (sck_rise)
                tx_q <= {tx_q[14:0], 1'b0};
        end
    end

    // first bit stands from select fall; later bits after each rise
    assign SERIAL_OUT    = tx_q[15];
    assign SERIAL_OUT_OE = sel;

    // =================================================================
    // register file written at select rise
    // device reset clears config registers
    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            for (i = 0; i < `NUM_REGS; i = i + 1)
                regs_q[i] <= `DATA_RESET;
        end else if (cs_rise && cnt_q == `BIT_CNT_FULL) begin
            regs_q[frame_addr] <= rx_q[`DATA_MSB:0];
        end
    end

    wire [`DATA_W-1:0] out_reg   = regs_q[`ADDR_OUT_CTRL];
    wire [`DATA_W-1:0] pwm_reg   = regs_q[`ADDR_PWM_CTRL];
    wire [`DATA_W-1:0] sense_reg = regs_q[`ADDR_SENSE_CTRL];
    wire pwm_en  = pwm_reg[`PWM_EN_BIT];
    wire clk_sel = pwm_reg[`CLK_SEL_BIT];

    // =================================================================
    // wake and mode
    // any wake source leaves sleep
    wire wake_any = rst_lvl | wake_lvl | in0_lvl | in1_lvl | pwm_clk_on_q;

    always @(posedge REF_CLK) begin
        if (SRST) begin
            AWAKE          <= 1'b0;
            FAIL_SAFE      <= 1'b0;
            WATCHDOG_START <= 1'b0;
        end else begin
            AWAKE          <= wake_any;
            FAIL_SAFE      <= wake_any & ~vdd_ok;
            WATCHDOG_START <= rst_rise;
        end
    end

    // =================================================================
    // output drive; fail-safe lets both direct pins drive the outputs, ORed with the register bits
    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            SWITCH_OUTPUT_ZERO <= 1'b0;
            SWITCH_OUTPUT_ONE  <= 1'b0;
        end else if (FAIL_SAFE || !(pwm_en && !clk_sel)) begin
            SWITCH_OUTPUT_ZERO <= in0_lvl | out_reg[`OUT0_BIT];
            SWITCH_OUTPUT_ONE  <= in1_lvl | out_reg[`OUT1_BIT];
        end else begin
            // input zero carries the pwm clock, so only its bit steers output zero
            SWITCH_OUTPUT_ZERO <= out_reg[`OUT0_BIT];
            SWITCH_OUTPUT_ONE  <= in1_lvl | out_reg[`OUT1_BIT];
        end
    end

    // =================================================================
    // pwm prescaler and clock-failure watch
    reg [`PWM_DIV_W-1:0] div_q;
    reg [`CLKFAIL_W-1:0] idle_q;
    // external pwm clock taken from input zero
    wire ext_pwm = pwm_en & ~clk_sel;

    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            div_q        <= 7'h00;
            PWM_TICK     <= 1'b0;
            idle_q       <= 16'h0000;
            CLOCK_FAIL   <= 1'b0;
            pwm_clk_on_q <= 1'b0;
        end else begin
            PWM_TICK <= 1'b0;
            // one tick per 128 rising clock edges
            if (ext_pwm && in0_rise) begin
                div_q <= div_q + 7'h01;
                if (div_q == `PWM_DIV_LAST)
                    PWM_TICK <= 1'b1;
            end
            // watch only with pwm on and external
            if (!ext_pwm || in0_rise) begin
                idle_q     <= 16'h0000;
                CLOCK_FAIL <= 1'b0;
            end else if (idle_q == `CLKFAIL_LIMIT) begin
                CLOCK_FAIL <= 1'b1;
            end else begin
                idle_q <= idle_q + 16'h0001;
            end
            pwm_clk_on_q <= ext_pwm & ~CLOCK_FAIL;
        end
    end

    // =================================================================
    // sense select
    // current, temperature or high impedance
    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            SENSE_SELECT     <= `SENSE_HIZ;
            SENSE_OUTPUT_HIZ <= 1'b1;
        end else begin
            SENSE_SELECT <= sense_reg[`SENSE_SEL_MSB:`SENSE_SEL_LSB];
            SENSE_OUTPUT_HIZ <=
                (sense_reg[`SENSE_SEL_MSB:`SENSE_SEL_LSB] == `SENSE_HIZ);
        end
    end

    // =================================================================
    // fault flag, open drain: drive low only
    // pull low while fault present
    assign FAULT_FLAG_LOW_OUT = 1'b0;
    assign FAULT_FLAG_LOW_OE  = FAULT_DETECTED | CLOCK_FAIL;
endmodule // lamp_spi_slave

`default_nettype wire

//--- tb/lamp_spi_slave_monitor.sv
// assertions on the serial slave's top-level pins
// assumes one clock domain: REF_CLK with SRST as its reset
`timescale 1ns/1ps
`default_nettype none
module lamp_spi_monitor (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic CHIP_SELECT_LOW,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_OE,
    input wire logic DEVICE_RESET_LOW,
    input wire logic FAULT_DETECTED,
    input wire logic SWITCH_OUTPUT_ZERO,
    input wire logic SWITCH_OUTPUT_ONE,
    input wire logic FAULT_FLAG_LOW_OE,
    input wire logic AWAKE,
    input wire logic CLOCK_FAIL,
    input wire logic WATCHDOG_START
);
    // ====================
    // pin properties
    // windows allow for the two-flop pin synchronisers
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);
    a_oe_idle: assert property (
        CHIP_SELECT_LOW [*5] |-> !SERIAL_OUT_OE) else $error("oe on idle");
    a_oe_live: assert property (
        !CHIP_SELECT_LOW [*5] |-> SERIAL_OUT_OE) else $error("oe off busy");
    a_so_hold: assert property (
        (!SERIAL_CLK && !CHIP_SELECT_LOW) [*6] |-> $stable(SERIAL_OUT))
        else $error("serial out moved with clock low");
    a_flag_pull: assert property (
        FAULT_DETECTED |-> ##[0:2] FAULT_FLAG_LOW_OE) else $error("no flag");
    a_flag_quiet: assert property (
        (!FAULT_DETECTED && !CLOCK_FAIL) [*3] |-> !FAULT_FLAG_LOW_OE)
        else $error("stray flag");
    a_wd_start: assert property (
        $rose(DEVICE_RESET_LOW) |-> ##[1:6] WATCHDOG_START)
        else $error("watchdog not started");
    a_wd_pulse: assert property (
        WATCHDOG_START |=> !WATCHDOG_START) else $error("start too long");
    a_sleep_off: assert property (
        !AWAKE [*3] |-> !(SWITCH_OUTPUT_ZERO || SWITCH_OUTPUT_ONE))
        else $error("output on in sleep");
    // main scenarios seen
    c_frame: cover property (SERIAL_OUT_OE ##1 !SERIAL_OUT_OE);
    c_wdog: cover property (WATCHDOG_START);
    c_fault: cover property (FAULT_FLAG_LOW_OE);
endmodule // lamp_spi_monitor
bind lamp_spi_slave lamp_spi_monitor mon (.*);
`default_nettype wire

//--- tb/spi_master_model.sv
// serial master stand-in driving select, clock and data pins
// assumes the 40 ns bench clock; pins move on its falling edge
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input  wire logic clk,
    input  wire logic so,
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic si
);
    // ====================
    // frames
    // released lines rest at their pull levels
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // msb first, clock low at select edges
    // clock period 320 ns, data moves on rise
    task automatic frame(input logic [15:0] tx, input int n,
                         output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            rx = {rx[14:0], so};
            sclk = 1'b1;
            si = tx[15 - i];
            repeat (4) @(negedge clk);
            sclk = 1'b0;
            repeat (4) @(negedge clk);
        end
        cs_n = 1'b1;
        si = 1'b0;
        // over 1 us before next frame
        repeat (30) @(negedge clk);
    endtask
endmodule // spi_master_model
`default_nettype wire

//--- tb/test_lamp_spi_slave.sv
// bench for the lamp switch serial slave, checked through a note queue
// assumes the master model and the bound monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_lamp_spi_slave;
    // ====================
    // stimulus and notes
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        rst_n = 1'b1;
    logic        sup = 1'b1;
    logic        wake, in0, in1, flt;
    logic [15:0] stat, rx, st;
    logic [3:0]  tk, wc;
    logic [8:0]  xe;
    logic [32:0] notes[$];
    event        seen;
    int          errors = 0;
    int          num_checks = 0;
    wire         cs_n, sclk, si, so, sw0, sw1, fe, hz, aw, fs, wd, tick, cf;
    wire [1:0]   sel;
    wire         so_d, oe;
    // a deselected output shows the inverse of its last bit to the master
    assign so = oe ? so_d : ~so_d;
    // 25 MHz clock, the device and its master
    always #20 clk = ~clk;
    lamp_spi_slave dut (.REF_CLK(clk), .SRST(srst),
        .CHIP_SELECT_LOW(cs_n), .SERIAL_CLK(sclk), .SERIAL_IN(si),
        .SERIAL_OUT(so_d), .SERIAL_OUT_OE(oe), .DEVICE_RESET_LOW(rst_n),
        .WAKE(wake), .DIRECT_INPUT_ZERO(in0), .DIRECT_INPUT_ONE(in1),
        .LOGIC_SUPPLY_OK(sup), .FAULT_DETECTED(flt), .STATUS_WORD(stat),
        .SWITCH_OUTPUT_ZERO(sw0), .SWITCH_OUTPUT_ONE(sw1),
        .FAULT_FLAG_LOW_OUT(), .FAULT_FLAG_LOW_OE(fe),
        .SENSE_SELECT(sel), .SENSE_OUTPUT_HIZ(hz), .AWAKE(aw),
        .FAIL_SAFE(fs), .WATCHDOG_START(wd), .PWM_TICK(tick),
        .CLOCK_FAIL(cf));
    spi_master_model mst (.clk(clk), .so(so), .cs_n(cs_n), .sclk(sclk),
        .si(si));
    // pulse tallies, since a one-cycle pulse is easy to miss
    always @(posedge clk) begin
        if (tick === 1'b1) tk <= tk + 4'h1;
        if (wd === 1'b1) wc <= wc + 4'h1;
    end
    // oldest note against the pins as they stand
    always @(seen) begin
        num_checks++;
        if (notes.pop_front() !==
            {rx, tk, wc, cf, sw1, sw0, sel, hz, fe, aw, fs}) begin
            errors++;
            $display("MISMATCH %0t pins %b", $time, {sw1, sw0, sel, hz});
        end
    end
    // note the expectation after n settling cycles
    task automatic chk(input int n, input logic [7:0] p);
        repeat (n) @(negedge clk);
        notes.push_back({st, xe, p});
        -> seen;
        @(negedge clk);
    endtask
    // one frame of n bits; a short one only returns part of the status
    task automatic wr(input logic [15:0] w, input int n);
        stat = 16'($urandom);
        st = stat >> (16 - n);
        mst.frame(w, n, rx);
    endtask
    // ====================
    // sequence
    initial begin
        {wake, in0, in1, flt} = 4'h0;
        {stat, rx, st, tk, wc, xe} = '0;
        stat = 16'($urandom(48));
        repeat (10) @(negedge clk);
        srst = 1'b0;
        chk(130, 8'h0a);
        wr(16'h0803, 16);
        chk(0, 8'hca);
        wr(16'h0800, 15);
        chk(0, 8'hca);
        for (int k = 3; k >= 0; k--) begin
            wr(16'h1800 | 16'(k), 16);
            chk(0, {2'b11, 2'(k), k == 0, 3'b010});
        end
        wr(16'h0800, 16);
        {in0, in1} = 2'b11;
        chk(10, 8'hca);
        {flt, in0, in1} = 3'b100;
        chk(10, 8'h0e);
        {flt, sup} = 2'b00;
        chk(10, 8'h0b);
        sup = 1'b1;
        wr(16'h1003, 16);
        chk(12400, 8'h0a);
        wr(16'h1001, 16);
        tk = 4'h0;
        repeat (600) begin
            in0 = ~in0;
            repeat (4) @(negedge clk);
        end
        xe = 9'h040;
        chk(0, 8'h0a);
        xe = 9'h041;
        chk(12400, 8'h0e);
        rst_n = 1'b0;
        xe = 9'h040;
        chk(20, 8'h08);
        wake = 1'b1;
        chk(10, 8'h0a);
        wake = 1'b0;
        // reset held low over 10 us
        repeat (280) @(negedge clk);
        rst_n = 1'b1;
        xe = 9'h042;
        chk(10, 8'h0a);
        print_verdict();
    end
    // hang guard at about twice the expected run
    initial begin
        #2400000;
        errors++;
        print_verdict();
    end
    // summary and verdict, the single end of the run
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
endmodule // test_lamp_spi_slave
`default_nettype wire
